// ==== design/mss_pkg.sv ====
/*
  Package for the motor start sequencer: sequencer states, drive
  patterns, APB register map, field positions, reset values and timing.
  Assumes a single 20 MHz core clock.
*/
package mss_pkg;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_POWER_ON   = 5'h00,
    ST_LOAD_NVM   = 5'h01,
    ST_STANDBY    = 5'h02,
    ST_ISD_CHECK  = 5'h03,
    ST_ISD_SENSE  = 5'h04,
    ST_SPIN_DIR   = 5'h05,
    ST_FWD_CHECK  = 5'h06,
    ST_REV_CHECK  = 5'h07,
    ST_REV_SPEED  = 5'h08,
    ST_REV_CL_DEC = 5'h09,
    ST_REV_OL_DEC = 5'h0A,
    ST_COAST_CHK  = 5'h0B,
    ST_COAST      = 5'h0C,
    ST_BRAKE_CHK  = 5'h0D,
    ST_BRAKE      = 5'h0E,
    ST_STARTUP    = 5'h0F,
    ST_OL_ACCEL   = 5'h10,
    ST_CLOSED     = 5'h11,
    ST_DIR_POLICY = 5'h12
  } mss_state_t;

  // Power stage pattern requested from the gate logic
  typedef enum logic [2:0] {
    DRV_OFF       = 3'h0,
    DRV_COAST     = 3'h1,
    DRV_BRAKE_LS  = 3'h2,
    DRV_BRAKE_HS  = 3'h3,
    DRV_STARTUP   = 3'h4,
    DRV_OPEN_LOOP = 3'h5,
    DRV_FOC       = 3'h6,
    DRV_SENSE     = 3'h7
  } mss_drive_t;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SPEED_THR = 8'h04;
  localparam logic [7:0] ADDR_BEMF_THR = 8'h08;
  localparam logic [7:0] ADDR_TIMES = 8'h0C;
  localparam logic [7:0] ADDR_BRAKE_CUR = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_SPEED_REF = 8'h18;

  // CTRL field positions
  localparam int CTRL_INITIAL_SPIN_DETECT_ENABLE = 0;
  localparam int CTRL_FWD_CATCH_EN = 1;
  localparam int CTRL_REV_DRV_EN = 2;
  localparam int CTRL_COAST_EN = 3;
  localparam int CTRL_BRAKE_EN = 4;
  localparam int CTRL_BRAKE_TYPE = 5;
  localparam int CTRL_BRAKE_SIDE = 6;
  localparam int CTRL_REV_POLICY = 7;
  localparam int CTRL_DEVICE_MODE_SELECT = 8;
  localparam int CTRL_DIR_CMD = 9;
  localparam int CTRL_BITS = 10;

  // Reset values (also the defaults taken from nonvolatile memory)
  localparam logic [9:0] CTRL_RST = 10'h011;
  localparam logic [31:0] SPEED_THR_RST = 32'h0200_0400;
  localparam logic [31:0] BEMF_THR_RST = 32'h0040_0080;
  localparam logic [31:0] TIMES_RST = 32'h0064_0064;
  localparam logic [31:0] BRAKE_CUR_RST = 32'h0010_0020;

  // Time units of the duration fields and load time of parameters
  localparam int CLK_HZ = 20_000_000;
  localparam int TIME_UNIT_US = 10;
  localparam int UNIT_CYC = (TIME_UNIT_US * (CLK_HZ / 1_000_000));
  localparam logic [7:0] UNIT_CYC_W = 8'(UNIT_CYC);
  localparam int NVM_LOAD_US = 2;
  localparam logic [7:0] NVM_LOAD_CYC = 8'(NVM_LOAD_US * (CLK_HZ / 1_000_000));

endpackage : mss_pkg

// ==== design/mss_tick_timer.sv ====
/*
  Countdown in units of a fixed number of clock cycles.
  Assumes start is a one-cycle pulse; a new start restarts the count.
*/
`timescale 1ns/1ps
`default_nettype none
module mss_tick_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [15:0] units,
  // Status
  output logic done
);

  typedef struct packed {
    logic [7:0] pre;
    logic [15:0] cnt;
    logic run;
    logic done;
  } mss_tmr_t;

  mss_tmr_t s_q, s_d;

  // Prescaler and unit counter; done pulses once when count expires
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.pre = 8'h00;
      s_d.cnt = units;
      s_d.run = 1'b1;
    end else if (s_q.run) begin
      if (s_q.cnt == 16'h0000) begin
        s_d.run = 1'b0;
        s_d.done = 1'b1;
      end else if (s_q.pre == mss_pkg::UNIT_CYC_W - 8'h01) begin
        s_d.pre = 8'h00;
        s_d.cnt = s_q.cnt - 16'h0001;
      end else begin
        s_d.pre = s_q.pre + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;

endmodule : mss_tick_timer
`default_nettype wire

// ==== design/mss_sequencer.sv ====
/*
  Motor start sequencer: decides how a sensorless three-phase drive is
  started, from standby through spin detection, catch, reverse drive,
  coast, brake, start-up and open loop into closed-loop FOC.
  Assumes measured back-EMF, speed, direction and phase current come
  synchronous to CORE_CLK from the estimator, and that the start-up
  method block reports completion with STARTUP_DONE.
*/
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Nonvolatile memory load handshake
  input wire logic NVM_READY,
  // Measurements from the estimator
  input wire logic [15:0] BEMF_LEVEL,
  input wire logic [15:0] SPEED_EST,
  input wire logic SPIN_DIR_EST,
  input wire logic [15:0] PHASE_CURRENT_MAX,
  input wire logic SPEED_COMMAND_WAKE_PIN,
  // Start-up method block
  input wire logic STARTUP_DONE,
  // Drive outputs
  output logic [2:0] DRIVE_MODE,
  output logic SEED_FROM_ISD,
  output logic SLEEP_REQ,
  output logic STANDBY_REQ,
  output logic PHASE_SENSE_EN,
  output logic READY
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    mss_pkg::mss_state_t st;
    logic [mss_pkg::CTRL_BITS-1:0] ctrl;
    logic [31:0] speed_thr;
    logic [31:0] bemf_thr;
    logic [31:0] times;
    logic [31:0] brake_cur;
    logic [15:0] speed_ref;
    logic dir_now;
    logic dir_pend;
    logic [7:0] load_cnt;
    logic [15:0] settle_cnt;
    logic tmr_start;
    logic [15:0] tmr_units;
    logic [2:0] drive;
    logic seed;
    logic sleep;
    logic standby;
    logic sense;
    logic ready;
    logic [31:0] rdata;
  } mss_seq_t;

  mss_seq_t s_q, s_d;
  logic tmr_done;
  logic apb_wr;
  logic apb_rd;
  logic [15:0] fwd_thr;
  logic [15:0] handoff_thr;
  logic [15:0] stat_thr;
  logic [15:0] tach_thr;
  logic [15:0] coast_units;
  logic [15:0] brake_units;
  logic [15:0] cur_thr;
  logic [15:0] settle_len;
  logic spin_fwd;

  ////////////////////////////////////////////////////////////////////////
  // Field views

  // Threshold and duration fields split out of the packed registers
  assign fwd_thr = s_q.speed_thr[15:0];
  assign handoff_thr = s_q.speed_thr[31:16];
  assign stat_thr = s_q.bemf_thr[15:0];
  assign tach_thr = s_q.bemf_thr[31:16];
  assign coast_units = s_q.times[15:0];
  assign brake_units = s_q.times[31:16];
  assign cur_thr = s_q.brake_cur[15:0];
  assign settle_len = s_q.brake_cur[31:16];
  assign spin_fwd = (SPIN_DIR_EST == s_q.dir_now); // Forward means commanded way

  // APB: zero wait states, every access completes in its access phase
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign PRDATA = s_q.rdata;

  ////////////////////////////////////////////////////////////////////////
  // Shared duration timer for coast and brake

  mss_tick_timer u_timer (
    .clk(CORE_CLK),
    .rst(RESET),
    .start(s_q.tmr_start),
    .units(s_q.tmr_units),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic: registers, then the sequencer

  always_comb begin
    s_d = s_q;
    s_d.tmr_start = 1'b0;

    // Register writes; the direction command is edge-captured
    if (apb_wr) begin
      unique case (PADDR)
        mss_pkg::ADDR_CTRL: s_d.ctrl = PWDATA[mss_pkg::CTRL_BITS-1:0];
        mss_pkg::ADDR_SPEED_THR: s_d.speed_thr = PWDATA;
        mss_pkg::ADDR_BEMF_THR: s_d.bemf_thr = PWDATA;
        mss_pkg::ADDR_TIMES: s_d.times = PWDATA;
        mss_pkg::ADDR_BRAKE_CUR: s_d.brake_cur = PWDATA;
        mss_pkg::ADDR_SPEED_REF: s_d.speed_ref = PWDATA[15:0];
        default: ;
      endcase
    end
    if (s_d.ctrl[mss_pkg::CTRL_DIR_CMD] != s_q.dir_now && !s_q.dir_pend) begin
      s_d.dir_pend = 1'b1; // Command latched until the sequencer acts on it
    end

    // Read data captured in the setup phase, held through access
    if (apb_rd && !PENABLE) begin
      unique case (PADDR)
        mss_pkg::ADDR_CTRL: s_d.rdata = {22'h000000, s_q.ctrl};
        mss_pkg::ADDR_SPEED_THR: s_d.rdata = s_q.speed_thr;
        mss_pkg::ADDR_BEMF_THR: s_d.rdata = s_q.bemf_thr;
        mss_pkg::ADDR_TIMES: s_d.rdata = s_q.times;
        mss_pkg::ADDR_BRAKE_CUR: s_d.rdata = s_q.brake_cur;
        mss_pkg::ADDR_STATUS: s_d.rdata = {22'h000000, s_q.ready, s_q.dir_now,
                                          s_q.drive, s_q.st};
        mss_pkg::ADDR_SPEED_REF: s_d.rdata = {16'h0000, s_q.speed_ref};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    unique case (s_q.st)
      // Peripherals set up, parameters pulled from memory
      mss_pkg::ST_POWER_ON: begin
        s_d.drive = mss_pkg::DRV_OFF;
        s_d.load_cnt = mss_pkg::NVM_LOAD_CYC;
        s_d.st = mss_pkg::ST_LOAD_NVM;
      end
      mss_pkg::ST_LOAD_NVM: begin
        if (s_q.load_cnt != 8'h00) begin
          s_d.load_cnt = s_q.load_cnt - 8'h01;
        end else if (NVM_READY) begin
          s_d.ready = 1'b1;
          s_d.dir_now = s_q.ctrl[mss_pkg::CTRL_DIR_CMD];
          s_d.dir_pend = 1'b0;
          s_d.st = mss_pkg::ST_STANDBY;
        end
      end
      // Idle with zero reference; low-power flavour from mode and pin
      mss_pkg::ST_STANDBY: begin
        s_d.drive = mss_pkg::DRV_OFF;
        s_d.seed = 1'b0;
        s_d.dir_now = s_q.ctrl[mss_pkg::CTRL_DIR_CMD]; // No motion, take command
        s_d.dir_pend = 1'b0;
        s_d.sleep = s_q.ctrl[mss_pkg::CTRL_DEVICE_MODE_SELECT] && !SPEED_COMMAND_WAKE_PIN;
        s_d.standby = !(s_q.ctrl[mss_pkg::CTRL_DEVICE_MODE_SELECT] && !SPEED_COMMAND_WAKE_PIN);
        if (s_q.speed_ref != 16'h0000) begin
          s_d.sleep = 1'b0;
          s_d.standby = 1'b0;
          s_d.st = mss_pkg::ST_ISD_CHECK;
        end
      end
      mss_pkg::ST_DIR_POLICY: begin
        s_d.dir_now = ~s_q.dir_now;
        s_d.dir_pend = 1'b0;
        s_d.st = s_q.ctrl[mss_pkg::CTRL_REV_POLICY] ? mss_pkg::ST_REV_SPEED
                                                    : mss_pkg::ST_ISD_CHECK;
      end
      mss_pkg::ST_ISD_CHECK: begin
        s_d.st = s_q.ctrl[mss_pkg::CTRL_INITIAL_SPIN_DETECT_ENABLE] ? mss_pkg::ST_ISD_SENSE
                                                : mss_pkg::ST_BRAKE_CHK;
      end
      // Phase voltages sensed with bridges off
      mss_pkg::ST_ISD_SENSE: begin
        s_d.drive = mss_pkg::DRV_SENSE;
        s_d.sense = 1'b1;
        if (BEMF_LEVEL < stat_thr || BEMF_LEVEL < tach_thr) begin
          s_d.st = mss_pkg::ST_BRAKE_CHK;
        end else begin
          s_d.st = mss_pkg::ST_SPIN_DIR;
        end
      end
      mss_pkg::ST_SPIN_DIR: begin
        s_d.sense = 1'b0;
        s_d.st = spin_fwd ? mss_pkg::ST_FWD_CHECK : mss_pkg::ST_REV_CHECK;
      end
      mss_pkg::ST_FWD_CHECK: begin
        if (!s_q.ctrl[mss_pkg::CTRL_FWD_CATCH_EN]) begin
          s_d.st = mss_pkg::ST_COAST_CHK;
        end else if (SPEED_EST > fwd_thr) begin
          s_d.seed = 1'b1;
          s_d.st = mss_pkg::ST_CLOSED;
        end else begin
          s_d.st = mss_pkg::ST_OL_ACCEL;
        end
      end
      mss_pkg::ST_REV_CHECK: begin
        s_d.st = s_q.ctrl[mss_pkg::CTRL_REV_DRV_EN] ? mss_pkg::ST_REV_SPEED
                                                    : mss_pkg::ST_COAST_CHK;
      end
      mss_pkg::ST_REV_SPEED: begin
        s_d.st = (SPEED_EST > handoff_thr) ? mss_pkg::ST_REV_CL_DEC
                                           : mss_pkg::ST_REV_OL_DEC;
      end
      // Reverse deceleration under FOC while speed allows it
      mss_pkg::ST_REV_CL_DEC: begin
        s_d.drive = mss_pkg::DRV_FOC;
        if (SPEED_EST <= handoff_thr) begin
          s_d.st = mss_pkg::ST_REV_OL_DEC;
        end
      end
      // Open loop down to zero; direction flip marks the crossover
      mss_pkg::ST_REV_OL_DEC: begin
        s_d.drive = mss_pkg::DRV_OPEN_LOOP;
        if (SPEED_EST == 16'h0000 || spin_fwd) begin
          s_d.st = mss_pkg::ST_OL_ACCEL;
        end
      end
      mss_pkg::ST_COAST_CHK: begin
        if (s_q.ctrl[mss_pkg::CTRL_COAST_EN]) begin
          s_d.tmr_start = 1'b1;
          s_d.tmr_units = coast_units;
          s_d.st = mss_pkg::ST_COAST;
        end else begin
          s_d.st = mss_pkg::ST_BRAKE_CHK;
        end
      end
      mss_pkg::ST_COAST: begin
        s_d.drive = mss_pkg::DRV_COAST;
        if (tmr_done) begin
          s_d.st = mss_pkg::ST_BRAKE_CHK;
        end
      end
      mss_pkg::ST_BRAKE_CHK: begin
        s_d.seed = 1'b0;
        if (s_q.ctrl[mss_pkg::CTRL_BRAKE_EN]) begin
          s_d.tmr_start = 1'b1;
          s_d.tmr_units = brake_units;
          s_d.settle_cnt = 16'h0000;
          s_d.st = mss_pkg::ST_BRAKE;
        end else begin
          s_d.st = mss_pkg::ST_STARTUP;
        end
      end
      // Brake: timer bounds both types; current type also exits on settle
      mss_pkg::ST_BRAKE: begin
        if (s_q.ctrl[mss_pkg::CTRL_BRAKE_TYPE]) begin
          s_d.drive = mss_pkg::DRV_BRAKE_LS;
          if (PHASE_CURRENT_MAX < cur_thr) begin
            s_d.settle_cnt = s_q.settle_cnt + 16'h0001;
          end else begin
            s_d.settle_cnt = 16'h0000;
          end
          if (s_q.settle_cnt >= settle_len || tmr_done) begin
            s_d.st = mss_pkg::ST_STARTUP;
          end
        end else begin
          s_d.drive = s_q.ctrl[mss_pkg::CTRL_BRAKE_SIDE] ? mss_pkg::DRV_BRAKE_HS
                                                         : mss_pkg::DRV_BRAKE_LS;
          if (tmr_done) begin
            s_d.st = mss_pkg::ST_STARTUP;
          end
        end
      end
      mss_pkg::ST_STARTUP: begin
        s_d.drive = mss_pkg::DRV_STARTUP;
        if (STARTUP_DONE) begin
          s_d.st = mss_pkg::ST_OL_ACCEL;
        end
      end
      mss_pkg::ST_OL_ACCEL: begin
        s_d.drive = mss_pkg::DRV_OPEN_LOOP;
        if (SPEED_EST > handoff_thr) begin
          s_d.st = mss_pkg::ST_CLOSED;
        end
      end
      mss_pkg::ST_CLOSED: begin
        s_d.drive = mss_pkg::DRV_FOC;
        s_d.seed = 1'b0;
      end
      default: s_d.st = mss_pkg::ST_POWER_ON;
    endcase

    // Run-time overrides: zero reference stops, direction change reroutes
    if (s_q.ready && s_q.st != mss_pkg::ST_STANDBY) begin
      if (s_q.speed_ref == 16'h0000) begin
        s_d.st = mss_pkg::ST_STANDBY;
        s_d.drive = mss_pkg::DRV_OFF;
        s_d.sense = 1'b0;
      end else if (s_q.dir_pend && s_q.st != mss_pkg::ST_DIR_POLICY) begin
        s_d.st = mss_pkg::ST_DIR_POLICY;
        s_d.sense = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  // Reset values stand in for the memory image until loading finishes
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
      s_q.st <= mss_pkg::ST_POWER_ON;
      s_q.ctrl <= mss_pkg::CTRL_RST;
      s_q.speed_thr <= mss_pkg::SPEED_THR_RST;
      s_q.bemf_thr <= mss_pkg::BEMF_THR_RST;
      s_q.times <= mss_pkg::TIMES_RST;
      s_q.brake_cur <= mss_pkg::BRAKE_CUR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Drive outputs straight from flip-flops
  assign DRIVE_MODE = s_q.drive;
  assign SEED_FROM_ISD = s_q.seed;
  assign SLEEP_REQ = s_q.sleep;
  assign STANDBY_REQ = s_q.standby;
  assign PHASE_SENSE_EN = s_q.sense;
  assign READY = s_q.ready;

endmodule : mss_sequencer
`default_nettype wire

// ==== testbench/mss_sequencer_chk.sv ====
/*
  Checker for the motor start sequencer: watches the top module ports.
  Assumes it is attached by the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer_chk (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // APB request
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  // Load handshake
  input wire logic NVM_READY,
  // Drive outputs
  input wire logic [2:0] DRIVE_MODE,
  input wire logic SEED_FROM_ISD,
  input wire logic SLEEP_REQ,
  input wire logic STANDBY_REQ,
  input wire logic PHASE_SENSE_EN,
  input wire logic READY
);
  logic [9:0] ctrl_q;
  logic [15:0] brk_units_q;
  logic [15:0] brk_cnt_q;
  logic wr_en;
  logic brk_on;
  int brk_lim;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign brk_on = DRIVE_MODE inside {mss_pkg::DRV_BRAKE_LS, mss_pkg::DRV_BRAKE_HS};
  // Limit allows the timer two units over, plus a few cycles of decision latency
  assign brk_lim = (int'(brk_units_q) + 2) * mss_pkg::UNIT_CYC + 4;

  // Shadow of written configuration and length of the current brake
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= mss_pkg::CTRL_RST;
      brk_units_q <= mss_pkg::TIMES_RST[31:16];
      brk_cnt_q <= 16'h0000;
    end else begin
      if (wr_en && PADDR == mss_pkg::ADDR_CTRL) ctrl_q <= PWDATA[9:0];
      if (wr_en && PADDR == mss_pkg::ADDR_TIMES) brk_units_q <= PWDATA[31:16];
      brk_cnt_q <= brk_on ? brk_cnt_q + 16'h0001 : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  sequence s_sense_rise;
    $rose(PHASE_SENSE_EN);
  endsequence
  sequence s_foc_soon;
    ##[0:2] DRIVE_MODE == mss_pkg::DRV_FOC;
  endsequence

  chk_drive_idle: assert property (!READY |-> DRIVE_MODE == mss_pkg::DRV_OFF)
    else $error("drive active before parameters loaded");
  chk_ready_load: assert property ($rose(READY) |-> $past(NVM_READY))
    else $error("ready without completed load");
  chk_standby_off: assert property (STANDBY_REQ [*2] |-> DRIVE_MODE == mss_pkg::DRV_OFF)
    else $error("drive active in standby");
  chk_sleep_mode: assert property (SLEEP_REQ |-> ctrl_q[mss_pkg::CTRL_DEVICE_MODE_SELECT] && !STANDBY_REQ)
    else $error("sleep without sleep mode selected");
  chk_sense_gate: assert property (PHASE_SENSE_EN |-> ctrl_q[mss_pkg::CTRL_INITIAL_SPIN_DETECT_ENABLE])
    else $error("phase sensing with detection disabled");
  chk_sense_drive: assert property (s_sense_rise |-> ##[0:2] DRIVE_MODE == mss_pkg::DRV_SENSE)
    else $error("sensing without sense drive");
  chk_seed_foc: assert property ($rose(SEED_FROM_ISD) |-> s_foc_soon)
    else $error("seeded entry not followed by closed loop");
  chk_coast_en: assert property (DRIVE_MODE == mss_pkg::DRV_COAST |-> ctrl_q[mss_pkg::CTRL_COAST_EN])
    else $error("coast while coast disabled");
  chk_brake_en: assert property (brk_on |-> ctrl_q[mss_pkg::CTRL_BRAKE_EN])
    else $error("brake while brake disabled");
  chk_brake_high: assert property (DRIVE_MODE == mss_pkg::DRV_BRAKE_HS |->
    ctrl_q[mss_pkg::CTRL_BRAKE_SIDE] && !ctrl_q[mss_pkg::CTRL_BRAKE_TYPE])
    else $error("high side brake not allowed here");
  chk_brake_low: assert property (DRIVE_MODE == mss_pkg::DRV_BRAKE_LS |->
    ctrl_q[mss_pkg::CTRL_BRAKE_TYPE] || !ctrl_q[mss_pkg::CTRL_BRAKE_SIDE])
    else $error("low side brake with high side chosen");
  chk_brake_bound: assert property (brk_on |-> int'(brk_cnt_q) <= brk_lim)
    else $error("brake outlasts its duration");
endmodule : mss_sequencer_chk

bind mss_sequencer mss_sequencer_chk i_chk (.CORE_CLK, .RESET, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .NVM_READY, .DRIVE_MODE, .SEED_FROM_ISD, .SLEEP_REQ, .STANDBY_REQ,
  .PHASE_SENSE_EN, .READY);
`default_nettype wire

// ==== testbench/mss_motor_model.sv ====
/*
  Behavioural motor and estimator: speed, direction and phase current
  react to the requested drive pattern. Assumes one clock with the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module mss_motor_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Drive pattern and commanded direction
  input wire logic [2:0] drive_mode,
  input wire logic cmd_dir,
  // Initial condition set by the bench
  input wire logic load,
  input wire logic [15:0] load_speed,
  input wire logic load_dir,
  input wire logic [15:0] load_current,
  // Estimates
  output logic [15:0] speed,
  output logic spin_dir,
  output logic [15:0] current,
  output logic startup_done
);
  logic [3:0] su_cnt;
  assign startup_done = su_cnt[3];

  // One step per cycle; a current of all ones never decays (stuck winding)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed <= 16'h0000;
      spin_dir <= 1'b0;
      current <= 16'h0000;
      su_cnt <= 4'h0;
    end else if (load) begin
      speed <= load_speed;
      spin_dir <= load_dir;
      current <= load_current;
    end else begin
      su_cnt <= (drive_mode == mss_pkg::DRV_STARTUP && su_cnt != 4'hF) ? su_cnt + 4'h1 : 4'h0;
      case (drive_mode)
        mss_pkg::DRV_BRAKE_LS, mss_pkg::DRV_BRAKE_HS, mss_pkg::DRV_COAST: begin
          if (speed != 16'h0000) speed <= speed - 16'h0001;
          if (current != 16'h0000 && current != 16'hFFFF) current <= current - 16'h0001;
        end
        mss_pkg::DRV_OPEN_LOOP, mss_pkg::DRV_FOC: begin
          if (spin_dir == cmd_dir) speed <= (speed < 16'h0FFF) ? speed + 16'h0004 : speed;
          else if (speed > 16'h0004) speed <= speed - 16'h0004;
          else begin
            speed <= 16'h0000;
            spin_dir <= cmd_dir;
          end
        end
        default: ;
      endcase
    end
  end
endmodule : mss_motor_model
`default_nettype wire

// ==== testbench/mss_sequencer_test.sv ====
/*
  Bench for the motor start sequencer: APB tasks and start scenarios.
  Assumes the motor model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic nvm = 1'b0, wake = 1'b1, cmd_dir = 1'b0, ld = 1'b0, ld_dir = 1'b0;
  logic [15:0] ld_spd = 16'h0000, ld_cur = 16'h0000, spd, cur;
  logic [31:0] prdata, rd;
  logic [2:0] drv;
  logic pready, perr, seed, slp, stby, sense, rdy, sdir, su_done, sense_seen = 1'b0;
  logic [7:0] obs;
  int failures = 0, tests_run = 0, cyc = 0;
  assign obs = {rdy, sense, stby, slp, seed, drv};

  always #25 clk = ~clk;

  mss_sequencer i_mss_sequencer (.CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(perr), .NVM_READY(nvm), .BEMF_LEVEL(spd), .SPEED_EST(spd), .SPIN_DIR_EST(sdir),
    .PHASE_CURRENT_MAX(cur), .SPEED_COMMAND_WAKE_PIN(wake), .STARTUP_DONE(su_done),
    .DRIVE_MODE(drv), .SEED_FROM_ISD(seed), .SLEEP_REQ(slp), .STANDBY_REQ(stby),
    .PHASE_SENSE_EN(sense), .READY(rdy));
  mss_motor_model i_mss_motor_model (.clk(clk), .rst(rst), .drive_mode(drv),
    .cmd_dir(cmd_dir), .load(ld), .load_speed(ld_spd), .load_dir(ld_dir),
    .load_current(ld_cur), .speed(spd), .spin_dir(sdir), .current(cur),
    .startup_done(su_done));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // One APB transfer; an idle cycle follows so the next call never rewrites psel
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    check({31'h0, perr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Outputs are sampled on the falling edge, well clear of updates
  task automatic wait_obs(input logic [7:0] m, input logic [7:0] e, input int n);
    int i = 0;
    @(negedge clk);
    while ((obs & m) !== e && i < n) begin
      @(negedge clk);
      i++;
    end
    check({24'h0, obs & m}, {24'h0, e});
    @(posedge clk);
  endtask : wait_obs

  task automatic wd(input logic [2:0] e, input int n);
    wait_obs(8'h07, {5'h00, e}, n);
  endtask : wd

  // Back to standby, reconfigure, set the motor, then command a speed
  task automatic start(input logic [31:0] ctl, input logic [15:0] s, input logic d,
                       input logic [15:0] c);
    apb(1'b1, mss_pkg::ADDR_SPEED_REF, 32'h0000_0000);
    wait_obs(8'h20, 8'h20, 20);
    apb(1'b1, mss_pkg::ADDR_CTRL, ctl);
    ld <= 1'b1;
    ld_spd <= s;
    ld_dir <= d;
    ld_cur <= c;
    @(posedge clk);
    ld <= 1'b0;
    apb(1'b1, mss_pkg::ADDR_SPEED_REF, 32'h0000_0100);
  endtask : start

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard: the scenarios need well under half of this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  always @(negedge clk) if (sense) sense_seen = 1'b1;

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (50) @(posedge clk);
    wait_obs(8'h80, 8'h00, 0);
    nvm <= 1'b1;
    wait_obs(8'h80, 8'h80, 5);
    apb(1'b0, mss_pkg::ADDR_CTRL, 32'h0);
    check(rd, {22'h0, mss_pkg::CTRL_RST});
    apb(1'b0, mss_pkg::ADDR_SPEED_THR, 32'h0);
    check(rd, mss_pkg::SPEED_THR_RST);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, mss_pkg::ADDR_TIMES, 32'h0003_0002);
    apb(1'b0, mss_pkg::ADDR_TIMES, 32'h0);
    check(rd, 32'h0003_0002);
    wait_obs(8'h30, 8'h20, 20);
    apb(1'b1, mss_pkg::ADDR_CTRL, 32'h0000_0111);
    wake <= 1'b0;
    wait_obs(8'h30, 8'h10, 10);
    wake <= 1'b1;
    wait_obs(8'h30, 8'h20, 10);
    // Fast forward spin is caught straight into closed loop
    start(32'h0000_0013, 16'h0800, 1'b0, 16'h0000);
    wait_obs(8'h40, 8'h40, 10);
    wait_obs(8'h08, 8'h08, 20);
    wd(mss_pkg::DRV_FOC, 5);
    start(32'h0000_0013, 16'h0100, 1'b0, 16'h0000);
    wait_obs(8'h0F, 8'h05, 20);
    wd(mss_pkg::DRV_FOC, 200);
    // Reversal by restart: no reverse drive or coast, so a timed brake
    cmd_dir <= 1'b1;
    apb(1'b1, mss_pkg::ADDR_CTRL, 32'h0000_0213);
    wait_obs(8'h40, 8'h40, 10);
    wd(mss_pkg::DRV_BRAKE_LS, 20);
    wd(mss_pkg::DRV_STARTUP, 1000);
    wd(mss_pkg::DRV_FOC, 2000);
    // Forward spin without catch coasts, then brakes on the high side
    start(32'h0000_0259, 16'h0300, 1'b1, 16'h0000);
    wd(mss_pkg::DRV_COAST, 20);
    wd(mss_pkg::DRV_BRAKE_HS, 1000);
    wd(mss_pkg::DRV_STARTUP, 1000);
    // Current brake settles early and stays low side despite the side bit
    start(32'h0000_0270, 16'h0000, 1'b1, 16'h0100);
    wd(mss_pkg::DRV_BRAKE_LS, 10);
    wd(mss_pkg::DRV_STARTUP, 500);
    // Current never settles: brake ends on its time limit
    start(32'h0000_0270, 16'h0000, 1'b1, 16'hFFFF);
    wd(mss_pkg::DRV_BRAKE_LS, 10);
    repeat (500) @(posedge clk);
    wd(mss_pkg::DRV_BRAKE_LS, 0);
    wd(mss_pkg::DRV_STARTUP, 1000);
    // Reverse spin driven through zero into the commanded direction
    start(32'h0000_0215, 16'h0800, 1'b0, 16'h0000);
    wd(mss_pkg::DRV_FOC, 20);
    wd(mss_pkg::DRV_OPEN_LOOP, 1000);
    wd(mss_pkg::DRV_FOC, 1000);
    check({31'h0, sdir}, 32'h1);
    // Reversal by policy 1 skips spin detection
    sense_seen = 1'b0;
    cmd_dir <= 1'b0;
    apb(1'b1, mss_pkg::ADDR_CTRL, 32'h0000_0095);
    wd(mss_pkg::DRV_OPEN_LOOP, 1500);
    check({31'h0, sense_seen}, 32'h0);
    test_done();
  end
endmodule : mss_sequencer_test
`default_nettype wire
